// ===== rtl/lcd_cmd_decoder.v
// Command decoder of a segment LCD driver: initialize, calibration reload,
// oscillator and charge-pump control. Bytes arrive as AXI4-Lite writes.
// Assumes an external clock on clk_pin_in from another domain.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "lcd_cmd_consts.vh"
// Behaviour
// [R1] Two bytes 3a then 04 reset the whole chip state; the decoder clears only its write-side registers and restarts calibration.
// [R2] Calibration reloads on reset, initialize and refresh byte d0.
// [R3] Host avoids power-down while a calibration reload runs.
// [R4] Byte with prefix 110011: bit1 clock-pin output, bit0 source select.
// [R5] Clock flag 0 keeps clock pin 3-state; 1 drives running clock. The decoder drives the pin only while source select is 0.
// [R6] Source flag 0 uses internal oscillator; 1 uses clock pin input.
// [R7] Pump enabled starts internal oscillator, even with external clock.
// [R8] Frame timing derives from the selected clock source.
// [R9] Host keeps external clock running once selected.
// [R10] Byte with prefix 110000: bit1 enables internal LCD supply.
// [R11] Pump bit0 selects multiplier: 0 twice, 1 three times.
// [R12] Host sends only defined opcodes.
// [R13] Qualifier 0 decodes commands; 1 writes display RAM data.
// [R14] First initialize byte waits; reset only if next command matches.
module lcd_cmd_decoder #(
   parameter FRAME_DIV = 16'h0100
) (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire osc_clk,
   input wire clk_pin_in,
   output reg clk_pin_out,
   output reg clk_pin_oe,
   output reg pump_enable,
   output reg pump_multiplier_sel,
   output reg internal_osc_run,
   output reg frame_tick,
   output reg [7:0] ram_data,
   output reg ram_write
);
   localparam ST_IDLE = 3'b001;
   localparam ST_LOAD = 3'b010;
   localparam ST_DONE = 3'b100;
   reg [15:0] aw_addr;
   reg aw_have;
   reg [7:0] w_byte;
   reg [8:0] w_word;
   reg w_have;
   reg w_skip;
   reg clock_pin_output_en;
   reg source_select;
   reg init_pending;
   reg soft_reset;
   reg cal_req;
   reg [2:0] cal_state;
   reg [1:0] cal_addr;
   reg [3:0] cal_wait;
   reg [7:0] cal_value0;
   reg [7:0] cal_value1;
   reg [7:0] cal_value2;
   reg [7:0] cal_value3;
   reg [2:0] osc_sync;
   reg [2:0] ext_sync;
   reg osc_level;
   reg ext_level;
   reg clk_prev;
   reg [15:0] frame_count;
   wire [7:0] cal_rdata;
   wire do_write;
   wire is_cmd;
   wire sel_clk;
   wire sel_edge;
   cal_store #(.AW(2), .DW(8)) u_cal (
      .aclk(aclk),
      .addr(cal_addr),
      .rdata(cal_rdata)
   );
   function prefix_match;
      input [7:0] b;
      input [5:0] p;
      begin
         prefix_match = (b[7:2] == p);
      end
   endfunction
   assign do_write = aw_have && w_have && !s_axi_bvalid;
   // Bit 8 of the data word carries the register-select qualifier
   assign is_cmd = do_write && (aw_addr[3:0] == `OFS_CMD) && !w_word[8] && !w_skip;
   // Synchronisers: the second and third stage must agree before a change counts
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_sync <= 3'h0;
         ext_sync <= 3'h0;
         osc_level <= 1'b0;
         ext_level <= 1'b0;
      end else begin
         osc_sync <= {osc_sync[1:0], osc_clk};
         ext_sync <= {ext_sync[1:0], clk_pin_in};
         if (osc_sync[2] == osc_sync[1]) begin
            osc_level <= osc_sync[2];
         end
         if (ext_sync[2] == ext_sync[1]) begin
            ext_level <= ext_sync[2];
         end
      end
   end
   assign sel_clk = source_select ? ext_level : osc_level; // [R6]
   assign sel_edge = sel_clk && !clk_prev;
   // AXI write channel and command decode
   always @(posedge aclk) begin
      if (!aresetn || soft_reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 16'h0000;
         w_byte <= 8'h00;
         w_word <= 9'h000;
         w_skip <= 1'b0;
         clk_pin_oe <= 1'b0;
         internal_osc_run <= 1'b1;
         clock_pin_output_en <= 1'b0;
         source_select <= 1'b0;
         pump_enable <= 1'b0;
         pump_multiplier_sel <= 1'b0;
         init_pending <= 1'b0;
         ram_data <= 8'h00;
         ram_write <= 1'b0;
         cal_req <= 1'b1; // [R2]
         soft_reset <= 1'b0;
      end else begin
         ram_write <= 1'b0;
         cal_req <= 1'b0;
         clk_pin_oe <= clock_pin_output_en && !source_select; // [R5]
         internal_osc_run <= !source_select || pump_enable; // [R7]
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr[15:0];
            aw_have <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_word <= s_axi_wstrb[1] ? s_axi_wdata[8:0] : {1'b0, s_axi_wdata[7:0]};
            w_skip <= !s_axi_wstrb[0];
            w_have <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            w_byte <= w_word[7:0];
            if (aw_addr[3:0] == `OFS_CMD) begin
               if (w_word[8] && !w_skip) begin
                  ram_data <= w_word[7:0]; // [R13]
                  ram_write <= 1'b1;
               end
            end else if (aw_addr[3:0] == `OFS_CTRL) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
         if (is_cmd) begin
            init_pending <= (w_word[7:0] == `INIT_FIRST_BYTE); // [R14]
            if (init_pending && w_word[7:0] == `INIT_SECOND_BYTE) begin
               soft_reset <= 1'b1; // [R1]
            end else if (w_word[7:0] == `REFRESH_BYTE) begin
               cal_req <= 1'b1; // [R2]
            end else if (prefix_match(w_word[7:0], `OSC_PREFIX)) begin
               clock_pin_output_en <= w_word[`BIT_CLK_OUT]; // [R4]
               source_select <= w_word[`BIT_SRC_SEL];
               clk_pin_oe <= w_word[`BIT_CLK_OUT] && !w_word[`BIT_SRC_SEL]; // [R5]
               internal_osc_run <= !w_word[`BIT_SRC_SEL] || pump_enable; // [R6] [R7]
            end else if (prefix_match(w_word[7:0], `PUMP_PREFIX)) begin
               pump_enable <= w_word[`BIT_PUMP_EN]; // [R10]
               pump_multiplier_sel <= w_word[`BIT_PUMP_MUL]; // [R11]
               internal_osc_run <= !source_select || w_word[`BIT_PUMP_EN]; // [R7]
            end
         end
      end
   end
   // Calibration reload sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         cal_state <= ST_IDLE;
         cal_addr <= 2'b00;
         cal_wait <= 4'h0;
         cal_value0 <= 8'h00;
         cal_value1 <= 8'h00;
         cal_value2 <= 8'h00;
         cal_value3 <= 8'h00;
      end else begin
         case (cal_state)
            ST_IDLE: begin
               if (cal_req) begin
                  cal_state <= ST_LOAD; // [R2]
                  cal_addr <= 2'b00;
                  cal_wait <= 4'h0;
               end
            end
            ST_LOAD: begin
               if (cal_wait == `CAL_CYCLES - 1) begin
                  cal_wait <= 4'h0;
                  case (cal_addr)
                     2'd0: cal_value0 <= cal_rdata;
                     2'd1: cal_value1 <= cal_rdata;
                     2'd2: cal_value2 <= cal_rdata;
                     default: cal_value3 <= cal_rdata;
                  endcase
                  if (cal_addr == 2'd3) begin
                     cal_state <= ST_DONE;
                  end else begin
                     cal_addr <= cal_addr + 2'd1;
                  end
               end else begin
                  cal_wait <= cal_wait + 4'h1;
               end
            end
            ST_DONE: begin
               cal_state <= cal_req ? ST_LOAD : ST_IDLE;
               cal_addr <= 2'b00;
            end
            default: cal_state <= ST_IDLE;
         endcase
      end
   end
   // AXI read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr[3:0])
            `OFS_CMD: s_axi_rdata <= {24'h000000, w_byte};
            `OFS_STATUS: s_axi_rdata <= {cal_value3, cal_value2, cal_value1, cal_value0[7:6],
               init_pending, cal_state != ST_IDLE, pump_multiplier_sel, pump_enable,
               clock_pin_output_en, source_select};
            `OFS_CTRL: s_axi_rdata <= {16'h0000, FRAME_DIV};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end
   end
   // Clock pin output level and frame timing
   always @(posedge aclk) begin
      if (!aresetn) begin
         clk_prev <= 1'b0;
         clk_pin_out <= 1'b0;
         frame_count <= 16'h0000;
         frame_tick <= 1'b0;
      end else begin
         clk_prev <= sel_clk;
         clk_pin_out <= osc_level;
         frame_tick <= 1'b0;
         if (sel_edge) begin
            if (frame_count == FRAME_DIV - 16'h0001) begin
               frame_count <= 16'h0000;
               frame_tick <= 1'b1; // [R8]
            end else begin
               frame_count <= frame_count + 16'h0001;
            end
         end
      end
   end
endmodule // lcd_cmd_decoder

// ===== rtl/lcd_cmd_consts.vh
// Constants of the LCD driver command decoder: opcodes, field positions,
// reset values and AXI4-Lite register offsets. Definitions only.
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH
`define INIT_FIRST_BYTE 8'h3a
`define INIT_SECOND_BYTE 8'h04
`define REFRESH_BYTE 8'hd0
`define OSC_PREFIX 6'h33
`define PUMP_PREFIX 6'h30
`define BIT_CLK_OUT 1
`define BIT_SRC_SEL 0
`define BIT_PUMP_EN 1
`define BIT_PUMP_MUL 0
`define OFS_CMD 4'h0
`define OFS_STATUS 4'h4
`define OFS_CTRL 4'h8
`define OFS_RAM_WORD 4'hc
`define CAL_WORDS 4
`define CAL_TIME_NS 40
`define CAL_CYCLES ((`CAL_TIME_NS + 9) / 10)
`define FRAME_DIV_DEFAULT 16'h0100
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== rtl/cal_store.v
// Small one-time-programmable calibration store, modelled as a ROM.
// Assumes a single clock; read data appear one cycle after the address.
`timescale 1ns/1ps
module cal_store #(
   parameter AW = 2,
   parameter DW = 8
) (
   input wire aclk,
   input wire [AW-1:0] addr,
   output reg [DW-1:0] rdata
);
   function [DW-1:0] rom;
      input [AW-1:0] a;
      begin
         rom = {{(DW-AW){1'b0}}, a} ^ {DW{1'b1}};
      end
   endfunction
   always @(posedge aclk) begin
      rdata <= rom(addr);
   end
endmodule // cal_store

// ===== test/lcd_cmd_monitor.sv
// Checker of the command decoder: handshake and control output timing.
// Assumes it is bound into the decoder and sees only its ports.
`timescale 1ns/1ps
module lcd_cmd_monitor #(
   parameter FRAME_DIV = 16'h0100
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire clk_pin_oe,
   input wire pump_enable,
   input wire internal_osc_run,
   input wire frame_tick,
   input wire ram_write
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   pump_osc_a: assert property (pump_enable |-> internal_osc_run)
      else $error("pump on with oscillator stopped");
   pin_drive_a: assert property (clk_pin_oe |-> internal_osc_run)
      else $error("clock pin driven without internal source");
   pump_cause_a: assert property ($changed(pump_enable) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("pump flag moved without a write");
   ram_pulse_a: assert property (ram_write |-> s_axi_bvalid ##1 !ram_write)
      else $error("ram write pulse malformed");
   // Gap assumes FRAME_DIV of at least 4
   tick_gap_a: assert property (frame_tick |=> !frame_tick [*3])
      else $error("frame ticks too close");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken during response");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // lcd_cmd_monitor
bind lcd_cmd_decoder lcd_cmd_monitor #(.FRAME_DIV(FRAME_DIV)) i_mon (.aclk, .aresetn, .s_axi_awready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .clk_pin_oe,
   .pump_enable, .internal_osc_run, .frame_tick, .ram_write);

// ===== test/clk_src.sv
// Clock sources around the decoder: internal oscillator and clock pin.
// Assumes the decoder drives the pin only while its enable is high.
`timescale 1ns/1ps
module clk_src (
   input wire ext_en,
   input wire pin_oe,
   input wire pin_out,
   output reg osc_clk,
   output wire pin
);
   reg ext_clk = 1'b0;
   reg float_pat = 1'b0;
   initial begin
      osc_clk = 1'b0;
      forever #22 osc_clk = ~osc_clk;
   end
   // Even half periods keep every toggle off the sampling edges at 5 ns plus multiples of 10 ns
   always #36 ext_clk = ~ext_clk;
   always #4 float_pat = ~float_pat;
   // Unpulled floating pin shows a changing pattern
   assign pin = pin_oe ? pin_out : (ext_en ? ext_clk : float_pat);
endmodule // clk_src

// ===== test/tb.sv
// Self-checking bench of the command decoder over AXI4-Lite.
// Assumes the decoder, its constants header and the clock source model.
`timescale 1ns/1ps
`include "lcd_cmd_consts.vh"
module tb;
   reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ext_en;
   reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg [1:0] r;
   reg [7:0] ram_last;
   reg p = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_clk, clk_pin_in;
   wire clk_pin_out, clk_pin_oe, pump_enable, pump_multiplier_sel, internal_osc_run, frame_tick, ram_write;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] ram_data;
   integer error_cnt = 0, checks_done = 0, ram_cnt = 0, i, n, k;
   lcd_cmd_decoder #(.FRAME_DIV(16'h0004)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .osc_clk, .clk_pin_in, .clk_pin_out, .clk_pin_oe, .pump_enable,
      .pump_multiplier_sel, .internal_osc_run, .frame_tick, .ram_data, .ram_write);
   clk_src i_src (.ext_en(ext_en), .pin_oe(clk_pin_oe), .pin_out(clk_pin_out), .osc_clk(osc_clk),
      .pin(clk_pin_in));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (ram_write === 1'b1) begin
         ram_cnt <= ram_cnt + 1;
         ram_last <= ram_data;
      end
   end
   task chk(input logic ok, input string m);
      begin
         checks_done = checks_done + 1;
         if (ok !== 1'b1) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %s", $time, m);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   // Offers address and data together, then waits for the write response
   task wr(input [31:0] a, input [7:0] v, input q);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {23'h000000, q, v};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
         end while (s_axi_bvalid !== 1'b1);
         s_axi_bready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task rd(input [31:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task t_ctrl;
      begin
         chk(pump_enable === 1'b0 && clk_pin_oe === 1'b0 && internal_osc_run === 1'b1, "reset");
         for (i = 0; i < 8; i = i + 1) begin
            wr(32'h0, (i < 4 ? 8'hc0 : 8'hc8) | i, 1'b0);
            rd(32'h4);
            if (i < 4) chk(pump_enable === i[1] && pump_multiplier_sel === i[0]
               && d[3:2] === {i[0], i[1]}, "pump");
            else chk(d[1:0] === i[1:0] && clk_pin_oe === (i[1] & ~i[0])
               && internal_osc_run === 1'b1, "osc");
         end
         wr(32'h0, 8'hc0, 1'b0);
         chk(internal_osc_run === 1'b0, "osc stop");
         wr(32'h0, 8'hc2, 1'b0);
         chk(internal_osc_run === 1'b1, "pump osc");
      end
   endtask
   task t_frame;
      begin
         ext_en <= 1'b1;
         for (k = 0; k < 2; k = k + 1) begin
            wr(32'h0, k ? 8'hce : 8'hcd, 1'b0);
            n = 0;
            i = 0;
            repeat (300) begin
               @(posedge aclk);
               if (frame_tick === 1'b1) n = n + 1;
               if (clk_pin_oe === 1'b1 && clk_pin_out === 1'b1 && p === 1'b0) i = i + 1;
               p = clk_pin_out;
            end
            // Model clocks: pin 72 ns, oscillator 44 ns; four selected edges make a frame
            chk(k ? (n > 14 && n < 20) : (n > 8 && n < 13), "frame rate");
            chk(k ? (i > 64 && i < 72) : (i == 0), "clock pin");
         end
      end
   endtask
   task t_cal;
      begin
         wr(32'h0, `REFRESH_BYTE, 1'b0);
         rd(32'h4);
         chk(d[4] === 1'b1, "busy");
         repeat (40) @(posedge aclk);
         rd(32'h4);
         chk(d[4] === 1'b0, "idle");
         k = ram_cnt;
         wr(32'h0, `INIT_FIRST_BYTE, 1'b1);
         rd(32'h4);
         chk(ram_cnt === k + 1 && ram_last === `INIT_FIRST_BYTE && d[5] === 1'b0, "ram");
      end
   endtask
   task t_init;
      begin
         wr(32'h0, `INIT_FIRST_BYTE, 1'b0);
         rd(32'h4);
         chk(d[5] === 1'b1 && pump_enable === 1'b1, "pending");
         wr(32'h0, 8'hc1, 1'b0);
         wr(32'h0, `INIT_SECOND_BYTE, 1'b0);
         chk(pump_enable === 1'b0 && pump_multiplier_sel === 1'b1, "discard");
         wr(32'h0, 8'hc3, 1'b0);
         wr(32'h0, `INIT_FIRST_BYTE, 1'b0);
         wr(32'h0, `INIT_SECOND_BYTE, 1'b0);
         rd(32'h4);
         chk(pump_enable === 1'b0 && pump_multiplier_sel === 1'b0 && d[4] === 1'b1, "init");
         wr(32'hc, 8'h00, 1'b0);
         chk(r === `RESP_SLVERR, "unmapped write");
         rd(32'hc);
         chk(r === `RESP_SLVERR, "unmapped");
      end
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ext_en} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      aresetn = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_ctrl;
      t_frame;
      t_cal;
      t_init;
      report_and_stop;
   end
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      report_and_stop;
   end
endmodule // tb
